// file: design/cmbr_pkg.sv
package cmbr_pkg;
   // register map: transmit buffer n sits at n * TX_STRIDE
   localparam logic [7:0] TX_STRIDE = 8'h10;
   localparam logic [3:0] OFS_TX_CTL = 4'h0;
   localparam logic [3:0] OFS_TX_SIDH = 4'h1;
   localparam logic [3:0] OFS_TX_SIDL = 4'h2;
   localparam logic [3:0] OFS_TX_EIDH = 4'h3;
   localparam logic [3:0] OFS_TX_EIDL = 4'h4;
   localparam logic [3:0] OFS_TX_DLC = 4'h5;
   localparam logic [3:0] OFS_TX_DATA = 4'h8;
   localparam logic [7:0] ADDR_RX0_CTL = 8'h30;
   localparam logic [7:0] ADDR_RX1_CTL = 8'h31;
   localparam logic [7:0] ADDR_RX0_SIDH = 8'h32;
   localparam logic [7:0] ADDR_RX1_SIDH = 8'h33;
   localparam logic [7:0] ADDR_TEC = 8'h34;
   localparam logic [7:0] ADDR_TX_END = 8'h30;
   // field positions
   localparam int BIT_TX_REQ = 3;
   localparam int BIT_TX_RTR = 6;
   localparam int BIT_TX_EXT_EN = 3;
   localparam int BIT_RX_FULL = 7;
   localparam int BIT_RX_MODE = 5;
   localparam int BIT_RX_RTR = 3;
   localparam int BIT_RX_DBEN = 2;
   localparam int BIT_RX_JUMP_OFS = 1;
   // writable masks; other bits are unimplemented and read zero
   localparam logic [7:0] MASK_TX_CTL = 8'h0b;
   localparam logic [7:0] MASK_TX_SIDL = 8'heb;
   localparam logic [7:0] MASK_TX_DLC = 8'h4f;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TEC = 8'h00;
   localparam logic [1:0] RST_RX_MODE = 2'h0;
   // acceptance modes
   localparam logic [1:0] MODE_ALL_VALID = 2'h0;
   localparam logic [1:0] MODE_STD_ONLY = 2'h1;
   localparam logic [1:0] MODE_EXT_ONLY = 2'h2;
   localparam logic [1:0] MODE_ANY = 2'h3;
   // counts
   localparam logic [3:0] MAX_PAYLOAD = 4'h8;
   localparam logic [7:0] TEC_STEP_DEFAULT = 8'h08;
   localparam logic [7:0] RECOVERY_LAST = 8'h7f;
   localparam logic [2:0] HIT_LAST_VALID = 3'h5;
   localparam logic [2:0] HIT_LAST_BUF0 = 3'h1;
   typedef enum logic [1:0] {
      LINK_ACTIVE = 2'b01,
      LINK_BUS_OFF = 2'b10
   } cmbr_link_e;
endpackage

// file: design/cmbr_top.sv
`timescale 1ns/10ps
module cmbr_top #(
   parameter logic [7:0] TEC_STEP = cmbr_pkg::TEC_STEP_DEFAULT
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [1:0] txSel,
   output logic [28:0] txFrameId,
   output logic txFrameExt,
   output logic txFrameRemote,
   output logic [3:0] txFrameLen,
   output logic [63:0] txFrameData,
   output logic [2:0] txSendRequest,
   output logic [2:0] txAbortReq,
   input wire logic txDone,
   input wire logic [1:0] txDoneSel,
   input wire logic txFault,
   input wire logic recessiveRun,
   output logic busOff,
   input wire logic rxValid,
   input wire logic rxFrameOk,
   input wire logic rxExtendedFrameFlag,
   input wire logic rxRemote,
   input wire logic [7:0] rxIdHigh,
   input wire logic [2:0] rxFilterHit,
   output logic [1:0] rxBufferFull
);

   typedef struct packed {
      logic [2:0] tx_send_request;
      logic [2:0][1:0] txPri;
      logic [2:0][7:0] txSidh;
      logic [2:0][7:0] txSidl;
      logic [2:0][7:0] txEidh;
      logic [2:0][7:0] txEidl;
      logic [2:0][7:0] txDlc;
      logic [2:0][7:0][7:0] txData;
      logic [2:0] txAbort;
      logic [7:0] tec;
      logic [7:0] recovery;
      cmbr_pkg::cmbr_link_e link;
      logic [1:0] rxFull;
      logic [1:0][1:0] rxMode;
      logic [1:0] rxRtr;
      logic dben;
      logic hit0;
      logic [2:0] hit1;
      logic [1:0][7:0] rxSidh;
      logic [7:0] rdData;
      logic [28:0] fId;
      logic fExt;
      logic fRemote;
      logic [3:0] fLen;
      logic [63:0] fData;
   } cmbr_state_s;

   cmbr_state_s st;
   cmbr_state_s next_st;

   function automatic logic accepts(input logic [1:0] mode, input logic ok,
                                    input logic ext);
      logic r;
      r = 1'b0;
      case (mode)
         cmbr_pkg::MODE_ANY: begin
            r = 1'b1;
         end
         cmbr_pkg::MODE_EXT_ONLY: begin
            r = ok & ext;
         end
         cmbr_pkg::MODE_STD_ONLY: begin
            r = ok & ~ext;
         end
         default: begin
            r = ok;
         end
      endcase
      return r;
   endfunction

   logic txHit;
   logic [1:0] wBuf;
   logic [3:0] wOfs;
   logic [1:0] rBuf;
   logic [3:0] rOfs;
   logic [8:0] tecSum;
   logic toBuf0;
   logic toBuf1;
   logic viaOverflow;
   logic [7:0] rdVal;

   always_comb begin
      next_st = st;
      next_st.txAbort = 3'h0;
      txHit = 1'b0;
      wBuf = regAddr[5:4];
      wOfs = regAddr[3:0];
      rBuf = regAddr[5:4];
      rOfs = regAddr[3:0];
      tecSum = {1'b0, st.tec} + {1'b0, TEC_STEP};
      toBuf0 = 1'b0;
      toBuf1 = 1'b0;
      viaOverflow = 1'b0;
      rdVal = cmbr_pkg::RST_BYTE;

      // hardware completion first so a software set in the same cycle wins
      if (txDone && txDoneSel != 2'h3) begin
         next_st.tx_send_request[txDoneSel] = 1'b0;
      end

      // register writes
      if (regWr) begin
         txHit = (regAddr < cmbr_pkg::ADDR_TX_END);
         if (txHit) begin
            case (wOfs)
               cmbr_pkg::OFS_TX_CTL: begin
                  next_st.txPri[wBuf] = regWrData[1:0];
                  if (regWrData[cmbr_pkg::BIT_TX_REQ]) begin
                     next_st.tx_send_request[wBuf] = 1'b1;
                  end else begin
                     next_st.tx_send_request[wBuf] = 1'b0;
                     // abort only when a pending request is withdrawn
                     next_st.txAbort[wBuf] = st.tx_send_request[wBuf];
                  end
               end
               cmbr_pkg::OFS_TX_SIDH: begin
                  next_st.txSidh[wBuf] = regWrData;
               end
               cmbr_pkg::OFS_TX_SIDL: begin
                  next_st.txSidl[wBuf] = regWrData & cmbr_pkg::MASK_TX_SIDL;
               end
               cmbr_pkg::OFS_TX_EIDH: begin
                  next_st.txEidh[wBuf] = regWrData;
               end
               cmbr_pkg::OFS_TX_EIDL: begin
                  next_st.txEidl[wBuf] = regWrData;
               end
               cmbr_pkg::OFS_TX_DLC: begin
                  next_st.txDlc[wBuf] = regWrData & cmbr_pkg::MASK_TX_DLC;
               end
               default: begin
                  if (wOfs >= cmbr_pkg::OFS_TX_DATA) begin
                     next_st.txData[wBuf][wOfs[2:0]] = regWrData;
                  end
               end
            endcase
         end else begin
            case (regAddr)
               cmbr_pkg::ADDR_RX0_CTL: begin
                  // full flag is clear-only from software
                  if (!regWrData[cmbr_pkg::BIT_RX_FULL]) begin
                     next_st.rxFull[0] = 1'b0;
                  end
                  next_st.rxMode[0] = regWrData[cmbr_pkg::BIT_RX_MODE +: 2];
                  next_st.dben = regWrData[cmbr_pkg::BIT_RX_DBEN];
               end
               cmbr_pkg::ADDR_RX1_CTL: begin
                  if (!regWrData[cmbr_pkg::BIT_RX_FULL]) begin
                     next_st.rxFull[1] = 1'b0;
                  end
                  next_st.rxMode[1] = regWrData[cmbr_pkg::BIT_RX_MODE +: 2];
               end
               cmbr_pkg::ADDR_RX0_SIDH: begin
                  next_st.rxSidh[0] = regWrData;
               end
               cmbr_pkg::ADDR_RX1_SIDH: begin
                  next_st.rxSidh[1] = regWrData;
               end
               default: begin
               end
            endcase
         end
      end

      // fault counter and bus-off recovery
      case (st.link)
         cmbr_pkg::LINK_ACTIVE: begin
            if (txFault) begin
               if (tecSum[8]) begin
                  // counter saturates while off the bus
                  next_st.tec = 8'hff;
                  next_st.link = cmbr_pkg::LINK_BUS_OFF;
                  next_st.recovery = 8'h00;
               end else begin
                  next_st.tec = tecSum[7:0];
               end
            end else if (txDone && st.tec != 8'h00) begin
               next_st.tec = st.tec - 8'h01;
            end
         end
         cmbr_pkg::LINK_BUS_OFF: begin
            if (recessiveRun) begin
               if (st.recovery == cmbr_pkg::RECOVERY_LAST) begin
                  next_st.tec = cmbr_pkg::RST_TEC;
                  next_st.recovery = 8'h00;
                  next_st.link = cmbr_pkg::LINK_ACTIVE;
               end else begin
                  next_st.recovery = st.recovery + 8'h01;
               end
            end
         end
         default: begin
            next_st.link = cmbr_pkg::LINK_ACTIVE;
         end
      endcase

      // receive steering; storing comes after writes so a set beats a clear
      if (rxValid) begin
         if (rxFilterHit <= cmbr_pkg::HIT_LAST_BUF0) begin
            if (accepts(st.rxMode[0], rxFrameOk, rxExtendedFrameFlag)) begin
               if (!st.rxFull[0]) begin
                  toBuf0 = 1'b1;
               end else if (st.dben && !st.rxFull[1]) begin
                  toBuf1 = 1'b1;
                  viaOverflow = 1'b1;
               end
            end
         end else if (rxFilterHit <= cmbr_pkg::HIT_LAST_VALID) begin
            if (accepts(st.rxMode[1], rxFrameOk, rxExtendedFrameFlag) && !st.rxFull[1]) begin
               toBuf1 = 1'b1;
            end
         end
      end
      // a full buffer with no overflow path keeps its contents
      if (toBuf0) begin
         next_st.rxFull[0] = 1'b1;
         next_st.rxRtr[0] = rxRemote;
         next_st.hit0 = rxFilterHit[0];
         next_st.rxSidh[0] = rxIdHigh;
      end
      if (toBuf1) begin
         next_st.rxFull[1] = 1'b1;
         next_st.rxRtr[1] = rxRemote;
         // codes 0 and 1 only reach here through the overflow path
         next_st.hit1 = viaOverflow ? {2'h0, rxFilterHit[0]} : rxFilterHit;
         next_st.rxSidh[1] = rxIdHigh;
      end

      // read path: data valid only in the cycle after the strobe
      if (regRd) begin
         if (regAddr < cmbr_pkg::ADDR_TX_END) begin
            case (rOfs)
               cmbr_pkg::OFS_TX_CTL: begin
                  rdVal = {4'h0, st.tx_send_request[rBuf], 1'b0, st.txPri[rBuf]};
               end
               cmbr_pkg::OFS_TX_SIDH: begin
                  rdVal = st.txSidh[rBuf];
               end
               cmbr_pkg::OFS_TX_SIDL: begin
                  rdVal = st.txSidl[rBuf];
               end
               cmbr_pkg::OFS_TX_EIDH: begin
                  rdVal = st.txEidh[rBuf];
               end
               cmbr_pkg::OFS_TX_EIDL: begin
                  rdVal = st.txEidl[rBuf];
               end
               cmbr_pkg::OFS_TX_DLC: begin
                  rdVal = st.txDlc[rBuf];
               end
               default: begin
                  if (rOfs >= cmbr_pkg::OFS_TX_DATA) begin
                     rdVal = st.txData[rBuf][rOfs[2:0]];
                  end
               end
            endcase
            if (rBuf == 2'h3) begin
               rdVal = cmbr_pkg::RST_BYTE;
            end
         end else begin
            case (regAddr)
               cmbr_pkg::ADDR_RX0_CTL: begin
                  // bit 1 mirrors the enable so both jump tables line up
                  rdVal = {st.rxFull[0], st.rxMode[0], 1'b0, st.rxRtr[0],
                           st.dben, st.dben, st.hit0};
               end
               cmbr_pkg::ADDR_RX1_CTL: begin
                  rdVal = {st.rxFull[1], st.rxMode[1], 1'b0, st.rxRtr[1], st.hit1};
               end
               cmbr_pkg::ADDR_RX0_SIDH: begin
                  rdVal = st.rxSidh[0];
               end
               cmbr_pkg::ADDR_RX1_SIDH: begin
                  rdVal = st.rxSidh[1];
               end
               cmbr_pkg::ADDR_TEC: begin
                  rdVal = st.tec;
               end
               default: begin
                  rdVal = cmbr_pkg::RST_BYTE;
               end
            endcase
         end
      end
      next_st.rdData = rdVal;

      // frame view of the buffer the bit engine is working on
      next_st.fId = 29'h0;
      next_st.fExt = 1'b0;
      next_st.fRemote = 1'b0;
      next_st.fLen = 4'h0;
      next_st.fData = 64'h0;
      if (txSel != 2'h3) begin
         next_st.fExt = st.txSidl[txSel][cmbr_pkg::BIT_TX_EXT_EN];
         if (next_st.fExt) begin
            next_st.fId = {st.txSidh[txSel], st.txSidl[txSel][7:5], st.txSidl[txSel][1:0],
                           st.txEidh[txSel], st.txEidl[txSel]};
         end else begin
            next_st.fId = {18'h0, st.txSidh[txSel], st.txSidl[txSel][7:5]};
         end
         next_st.fRemote = st.txDlc[txSel][cmbr_pkg::BIT_TX_RTR];
         // reserved codes still send a full payload and no more
         if (st.txDlc[txSel][3:0] > cmbr_pkg::MAX_PAYLOAD) begin
            next_st.fLen = cmbr_pkg::MAX_PAYLOAD;
         end else begin
            next_st.fLen = st.txDlc[txSel][3:0];
         end
         next_st.fData = st.txData[txSel];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
         st.tec <= cmbr_pkg::RST_TEC;
         st.link <= cmbr_pkg::LINK_ACTIVE;
         st.rxMode <= {cmbr_pkg::RST_RX_MODE, cmbr_pkg::RST_RX_MODE};
      end else begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign txFrameId = st.fId;
   assign txFrameExt = st.fExt;
   assign txFrameRemote = st.fRemote;
   assign txFrameLen = st.fLen;
   assign txFrameData = st.fData;
   assign txSendRequest = st.tx_send_request;
   assign txAbortReq = st.txAbort;
   assign busOff = st.link[1]; // one-hot state, so the bus-off bit is the flag itself
   assign rxBufferFull = st.rxFull;

endmodule

// file: verif/cmbr_asserts.sv
`timescale 1ns/10ps
module cmbr_asserts #(
   parameter logic [7:0] TEC_STEP = 8'h08
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic [3:0] txFrameLen,
   input wire logic [2:0] txSendRequest,
   input wire logic [2:0] txAbortReq,
   input wire logic txDone,
   input wire logic [1:0] txDoneSel,
   input wire logic recessiveRun,
   input wire logic busOff,
   input wire logic rxValid,
   input wire logic [2:0] rxFilterHit,
   input wire logic [1:0] rxBufferFull
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   logic ctl1Wr;
   assign ctl1Wr = regWr && regAddr == 8'h10;
   AST_REQ_SET: assert property (ctl1Wr && regWrData[3] |=> txSendRequest[1])
      else $error("send request not set");
   AST_DONE_CLR: assert property (txDone && txDoneSel == 2'h1
      && !(ctl1Wr && regWrData[3]) |=> !txSendRequest[1])
      else $error("send request not cleared by done");
   AST_ABORT: assert property (ctl1Wr && !regWrData[3] && txSendRequest[1]
      |=> txAbortReq[1] && !txSendRequest[1] ##1 !txAbortReq[1])
      else $error("abort pulse wrong");
   AST_LEN_MAX: assert property (txFrameLen <= 4'h8)
      else $error("payload length above eight");
   AST_BUSOFF_HOLD: assert property (busOff && !recessiveRun |=> busOff)
      else $error("bus-off left without recessive run");
   AST_RX1_SET: assert property ($rose(rxBufferFull[1]) |-> $past(rxValid))
      else $error("buffer 1 full without frame");
   AST_RX0_SRC: assert property ($rose(rxBufferFull[0])
      |-> $past(rxValid) && $past(rxFilterHit) < 3'h2)
      else $error("buffer 0 filled by wrong filter");
   AST_FULL_KEEP: assert property (rxBufferFull[1] && !(regWr && regAddr == 8'h31)
      |=> rxBufferFull[1])
      else $error("full buffer lost its flag");
   AST_BIT4_ZERO: assert property (regRd && regAddr[7:1] == 7'h18 |=> !regRdData[4])
      else $error("control bit 4 not zero");
   AST_JT_COPY: assert property (regRd && regAddr == 8'h30 |=> regRdData[1] == regRdData[2])
      else $error("offset bit differs from enable");
endmodule
bind cmbr_top cmbr_asserts #(.TEC_STEP(TEC_STEP)) chk (.clk(clk), .srst(srst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .txFrameLen(txFrameLen), .txSendRequest(txSendRequest), .txAbortReq(txAbortReq),
   .txDone(txDone), .txDoneSel(txDoneSel), .recessiveRun(recessiveRun), .busOff(busOff),
   .rxValid(rxValid), .rxFilterHit(rxFilterHit), .rxBufferFull(rxBufferFull));

// file: verif/cmbr_bus_node.sv
`timescale 1ns/10ps
module cmbr_bus_node (
   input wire logic clk,
   output logic txDone,
   output logic [1:0] txDoneSel,
   output logic txFault,
   output logic recessiveRun,
   output logic rxValid,
   output logic rxFrameOk,
   output logic rxExtendedFrameFlag,
   output logic rxRemote,
   output logic [7:0] rxIdHigh,
   output logic [2:0] rxFilterHit
);
   initial begin
      {txDone, txDoneSel, txFault, recessiveRun} = 5'h00;
      {rxValid, rxFrameOk, rxExtendedFrameFlag, rxRemote, rxIdHigh, rxFilterHit} = 15'h0000;
   end
   // kind 0 fault, 1 successful send, 2 one recessive run
   task automatic pulse(input int kind, input logic [1:0] sel);
      @(posedge clk);
      txFault <= kind == 0;
      txDone <= kind == 1;
      recessiveRun <= kind == 2;
      txDoneSel <= sel;
      @(posedge clk);
      {txFault, txDone, recessiveRun} <= 3'h0;
      txDoneSel <= ~sel;
   endtask
   // qualifiers are inverted once the offer is over so stale values never look valid
   task automatic offer(input logic ok, ext, rem, input logic [7:0] id, input logic [2:0] hit);
      @(posedge clk);
      rxValid <= 1'b1;
      {rxFrameOk, rxExtendedFrameFlag, rxRemote, rxIdHigh, rxFilterHit} <= {ok, ext, rem, id, hit};
      @(posedge clk);
      rxValid <= 1'b0;
      {rxFrameOk, rxExtendedFrameFlag, rxRemote, rxIdHigh, rxFilterHit} <= ~{ok, ext, rem, id, hit};
   endtask
endmodule

// file: verif/test_can_message_buffer_regs.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_can_message_buffer_regs;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] regAddr, regWrData, regRdData;
   logic regWr, regRd, txFrameExt, txFrameRemote, txDone, txFault, recessiveRun, busOff;
   logic rxValid, rxFrameOk, rxExt, rxRemote, ok, ext, acc;
   logic [1:0] txSel, txDoneSel, rxBufferFull;
   logic [28:0] txFrameId;
   logic [3:0] txFrameLen;
   logic [63:0] txFrameData;
   logic [2:0] txSendRequest, txAbortReq, rxFilterHit;
   logic [7:0] rxIdHigh;
   int errTotal = 0;
   int testsRun = 0;
   int cyc = 0;
   logic [23:0] rows [9] = '{24'h04a5a5, 24'h1c3c3c, 24'h2fffff, 24'h05ff4f, 24'h345500,
      24'h30ff66, 24'h31ff60, 24'h328181, 24'h3f1200};
   cmbr_top dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txSel(txSel),
      .txFrameId(txFrameId), .txFrameExt(txFrameExt), .txFrameRemote(txFrameRemote),
      .txFrameLen(txFrameLen), .txFrameData(txFrameData), .txSendRequest(txSendRequest),
      .txAbortReq(txAbortReq), .txDone(txDone), .txDoneSel(txDoneSel), .txFault(txFault),
      .recessiveRun(recessiveRun), .busOff(busOff), .rxValid(rxValid), .rxFrameOk(rxFrameOk),
      .rxExtendedFrameFlag(rxExt), .rxRemote(rxRemote), .rxIdHigh(rxIdHigh),
      .rxFilterHit(rxFilterHit), .rxBufferFull(rxBufferFull));
   cmbr_bus_node node (.clk(clk), .txDone(txDone), .txDoneSel(txDoneSel), .txFault(txFault),
      .recessiveRun(recessiveRun), .rxValid(rxValid), .rxFrameOk(rxFrameOk),
      .rxExtendedFrameFlag(rxExt), .rxRemote(rxRemote), .rxIdHigh(rxIdHigh),
      .rxFilterHit(rxFilterHit));
   always #5 clk = ~clk;
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errTotal++;
         giveVerdict();
      end
   end
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rc(input logic [7:0] a, e);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 `CHK($sformatf("reg %h", a), e, regRdData)
   endtask
   initial begin
      {regAddr, regWrData, regWr, regRd} = 18'h00000;
      txSel = 2'h3;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rc(8'h30, 8'h00);
      rc(8'h31, 8'h00);
      rc(8'h34, 8'h00);
      for (int i = 0; i < 9; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rc(rows[i][23:16], rows[i][7:0]);
      end
      rc(8'h30, 8'h66);
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 3; k++) begin
            ok = k != 2;
            ext = k == 1;
            acc = m == 3 || ok && (m == 0 || m == 1 && !ext || m == 2 && ext);
            wr(8'h31, {1'b0, 2'(m), 5'h00});
            node.offer(ok, ext, 1'b0, 8'h40, 3'h3);
            #1 `CHK("full1", acc, rxBufferFull[1])
         end
      end
      rc(8'h31, 8'he3);
      wr(8'h31, 8'h00);
      wr(8'h30, 8'h04);
      rc(8'h30, 8'h06);
      node.offer(1'b1, 1'b0, 1'b1, 8'h77, 3'h1);
      rc(8'h30, 8'h8f);
      rc(8'h32, 8'h77);
      node.offer(1'b1, 1'b1, 1'b0, 8'h99, 3'h0);
      rc(8'h31, 8'h80);
      rc(8'h33, 8'h99);
      node.offer(1'b1, 1'b0, 1'b0, 8'h55, 3'h2);
      rc(8'h33, 8'h99);
      wr(8'h30, 8'h04);
      #1 `CHK("fullb", 2'h2, rxBufferFull)
      wr(8'h11, 8'haa);
      wr(8'h12, 8'h28);
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h5a);
      wr(8'h15, 8'h4c);
      txSel <= 2'h1;
      repeat (2) @(posedge clk);
      #1 `CHK("id", {8'haa, 3'h1, 2'h0, 8'h00, 8'h5a}, txFrameId)
      `CHK("ext", 1'b1, txFrameExt)
      `CHK("rtr", 1'b1, txFrameRemote)
      `CHK("len", 4'h8, txFrameLen)
      `CHK("pay", 8'h3c, txFrameData[39:32])
      wr(8'h15, 8'h05);
      wr(8'h12, 8'h20);
      @(posedge clk);
      #1 `CHK("len", 4'h5, txFrameLen)
      `CHK("rtr", 1'b0, txFrameRemote)
      `CHK("sid", 11'h551, txFrameId[10:0])
      `CHK("ext", 1'b0, txFrameExt)
      wr(8'h10, 8'h08);
      #1 `CHK("req", 3'h2, txSendRequest)
      node.pulse(1, 2'h1);
      #1 `CHK("req", 3'h0, txSendRequest)
      wr(8'h10, 8'h08);
      wr(8'h10, 8'h00);
      #1 `CHK("abort", 3'h2, txAbortReq)
      `CHK("req", 3'h0, txSendRequest)
      repeat (31) node.pulse(0, 2'h0);
      rc(8'h34, 8'hf8);
      `CHK("busoff", 1'b0, busOff)
      node.pulse(0, 2'h0);
      rc(8'h34, 8'hff);
      `CHK("busoff", 1'b1, busOff)
      repeat (127) node.pulse(2, 2'h0);
      #1 `CHK("busoff", 1'b1, busOff)
      node.pulse(2, 2'h0);
      rc(8'h34, 8'h00);
      `CHK("busoff", 1'b0, busOff)
      // a second reset in mid-run must empty both receive buffers again
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rc(8'h30, 8'h00);
      rc(8'h31, 8'h00);
      node.offer(1'b1, 1'b0, 1'b0, 8'h11, 3'h6);
      #1 `CHK("resv", 2'h0, rxBufferFull)
      node.offer(1'b1, 1'b0, 1'b0, 8'h22, 3'h1);
      node.offer(1'b1, 1'b1, 1'b0, 8'h33, 3'h0);
      #1 `CHK("nodb", 2'h1, rxBufferFull)
      rc(8'h32, 8'h22);
      giveVerdict();
   end
endmodule
